/* verilog/bsc_defs.vh */
`ifndef BSC_DEFS_VH
`define BSC_DEFS_VH
`define BSC_IDX_CTRL 8'h05
`define BSC_IDX_MISC 8'h50
`define BSC_IDX_STAT 8'h58
`define BSC_IDX_IRQ 8'h60
`define BSC_IDX_MASK 8'h64
`define BSC_BIT_PWR 7
`define BSC_BIT_CHKEN 0
`define BSC_BIT_GND 2
`define BSC_BIT_VCC 1
`define BSC_BIT_PAIR 0
`define BSC_RST_CTRL 8'h00
`define BSC_RST_MISC 8'h00
`define BSC_RST_STAT 3'h7
`define BSC_RST_MASK 3'h0
`define BSC_TEST_CYC 16'h0100
`define BSC_SETTLE_CYC 16'h0010
`endif

/* verilog/bsc_check.v */
`include "bsc_defs.vh"
`timescale 1ns/1ns
`default_nettype none
module bsc_check #(
    parameter [15:0] TEST_CYC = `BSC_TEST_CYC,
    parameter [15:0] SETTLE_CYC = `BSC_SETTLE_CYC
) (
    input wire clock_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    input wire gnd_short_i,
    input wire vcc_short_i,
    input wire pair_short_i,
    output reg bridge_tristate_o,
    output reg test_gnd_o,
    output reg test_vcc_o,
    output reg test_pair_o,
    output reg irq_o
);
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_GND = 3'd1;
    localparam [2:0] ST_VCC = 3'd2;
    localparam [2:0] ST_PAIR = 3'd3;
    localparam [2:0] ST_RUN = 3'd4;
    localparam [2:0] ST_FAIL = 3'd5;

    // Sense pins come from analog comparators, so each passes two flip-flops
    reg gs1_q;
    reg gs2_q;
    reg vs1_q;
    reg vs2_q;
    reg ps1_q;
    reg ps2_q;

    reg [7:0] ctrl_q;
    reg [7:0] misc_q;
    reg [2:0] mask_q;
    reg [2:0] irq_q;
    reg [2:0] stat_q;
    reg [2:0] stat_d;
    reg stat_valid_q;
    reg stat_valid_d;
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [15:0] cnt_q;
    reg [15:0] cnt_d;
    reg pwr_prev_q;
    reg fail_q;
    reg fail_d;
    reg tri_d;
    reg tgnd_d;
    reg tvcc_d;
    reg tpair_d;
    reg [2:0] ev;
    reg [31:0] rdata_d;

    // Registers sit on word addresses: the byte address is four times the index
    function hit;
        input [11:0] a;
        input [7:0] idx;
        begin
            hit = (a == {2'b00, idx, 2'b00});
        end
    endfunction

    function mapped;
        input [11:0] a;
        begin
            mapped = hit(a, `BSC_IDX_CTRL) | hit(a, `BSC_IDX_MISC) | hit(a, `BSC_IDX_STAT) |
                     hit(a, `BSC_IDX_IRQ) | hit(a, `BSC_IDX_MASK);
        end
    endfunction

    wire acc = psel_i & penable_i & ~pready_o;
    wire wr = acc & pwrite_i;
    wire rd = acc & ~pwrite_i;
    wire pwr_on = ctrl_q[`BSC_BIT_PWR];
    wire pwr_rise = pwr_on & ~pwr_prev_q;
    wire phase_end = (cnt_q == TEST_CYC - 16'h0001);
    wire irq_rd = rd & hit(paddr_i, `BSC_IDX_IRQ);
    // Set wins over the read clear, so a completion is never lost
    wire [2:0] irq_next = (irq_rd ? 3'h0 : irq_q) | ev;

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gs1_q <= 1'b0;
            gs2_q <= 1'b0;
            vs1_q <= 1'b0;
            vs2_q <= 1'b0;
            ps1_q <= 1'b0;
            ps2_q <= 1'b0;
        end else if (ce_i) begin
            gs1_q <= gnd_short_i;
            gs2_q <= gs1_q;
            vs1_q <= vcc_short_i;
            vs2_q <= vs1_q;
            ps1_q <= pair_short_i;
            ps2_q <= ps1_q;
        end
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= `BSC_RST_CTRL;
            misc_q <= `BSC_RST_MISC;
            mask_q <= `BSC_RST_MASK;
            pwr_prev_q <= 1'b0;
        end else if (ce_i) begin
            if (wr && hit(paddr_i, `BSC_IDX_CTRL)) begin
                ctrl_q <= pwdata_i[7:0];
            end
            if (wr && hit(paddr_i, `BSC_IDX_MISC)) begin
                misc_q <= pwdata_i[7:0];
            end
            if (wr && hit(paddr_i, `BSC_IDX_MASK)) begin
                mask_q <= pwdata_i[2:0];
            end
            // Writes to the status address are dropped: it is read-only
            pwr_prev_q <= pwr_on;
        end
    end

    always @* begin
        rdata_d = 32'h00000000;
        if (hit(paddr_i, `BSC_IDX_CTRL)) begin
            rdata_d = {24'h000000, ctrl_q};
        end
        if (hit(paddr_i, `BSC_IDX_MISC)) begin
            rdata_d = {24'h000000, misc_q};
        end
        if (hit(paddr_i, `BSC_IDX_STAT)) begin
            rdata_d = {23'h000000, stat_valid_q, 5'h00, stat_q};
        end
        if (hit(paddr_i, `BSC_IDX_IRQ)) begin
            rdata_d = {29'h00000000, irq_q};
        end
        if (hit(paddr_i, `BSC_IDX_MASK)) begin
            rdata_d = {29'h00000000, mask_q};
        end
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h00000000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else if (ce_i) begin
            pready_o <= acc;
            pslverr_o <= acc & ~mapped(paddr_i);
            if (rd) begin
                prdata_o <= rdata_d;
            end
        end
    end

    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        fail_d = fail_q;
        stat_d = stat_q;
        stat_valid_d = stat_valid_q;
        tri_d = bridge_tristate_o;
        tgnd_d = test_gnd_o;
        tvcc_d = test_vcc_o;
        tpair_d = test_pair_o;
        ev = 3'h0;
        if (!pwr_on) begin
            // Dropping power enable aborts any test and always tristates the bridge
            state_d = ST_IDLE;
            tri_d = 1'b1;
            tgnd_d = 1'b0;
            tvcc_d = 1'b0;
            tpair_d = 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (pwr_rise) begin
                        stat_valid_d = 1'b1;
                        cnt_d = 16'h0000;
                        fail_d = 1'b0;
                        if (misc_q[`BSC_BIT_CHKEN]) begin
                            state_d = ST_GND;
                            tgnd_d = 1'b1;
                            tri_d = 1'b1;
                        end else begin
                            state_d = ST_RUN;
                            tri_d = 1'b0;
                        end
                    end
                end
                ST_GND: begin
                    cnt_d = cnt_q + 16'h0001;
                    if (phase_end) begin
                        stat_d[`BSC_BIT_GND] = ~gs2_q;
                        fail_d = fail_q | gs2_q;
                        cnt_d = 16'h0000;
                        tgnd_d = 1'b0;
                        tvcc_d = 1'b1;
                        state_d = ST_VCC;
                    end
                end
                ST_VCC: begin
                    cnt_d = cnt_q + 16'h0001;
                    if (phase_end) begin
                        stat_d[`BSC_BIT_VCC] = ~vs2_q;
                        fail_d = fail_q | vs2_q;
                        cnt_d = 16'h0000;
                        tvcc_d = 1'b0;
                        tpair_d = 1'b1;
                        state_d = ST_PAIR;
                    end
                end
                ST_PAIR: begin
                    cnt_d = cnt_q + 16'h0001;
                    if (phase_end) begin
                        stat_d[`BSC_BIT_PAIR] = ~ps2_q;
                        fail_d = fail_q | ps2_q;
                        cnt_d = 16'h0000;
                        tpair_d = 1'b0;
                        // Irq bits: 0 done, 1 fail, 2 pass
                        ev[0] = 1'b1;
                        ev[1] = fail_q | ps2_q;
                        ev[2] = ~(fail_q | ps2_q);
                        if (fail_q | ps2_q) begin
                            state_d = ST_FAIL;
                        end else begin
                            state_d = ST_RUN;
                            tri_d = 1'b0;
                        end
                    end
                end
                // No sensing here, so a short during operation goes unseen
                ST_RUN: begin
                    state_d = ST_RUN;
                end
                ST_FAIL: begin
                    tri_d = 1'b1;
                end
                default: begin
                    state_d = ST_IDLE;
                    tri_d = 1'b1;
                end
            endcase
        end
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat_q <= `BSC_RST_STAT;
            stat_valid_q <= 1'b0;
            state_q <= ST_IDLE;
            cnt_q <= 16'h0000;
            fail_q <= 1'b0;
            bridge_tristate_o <= 1'b1;
            test_gnd_o <= 1'b0;
            test_vcc_o <= 1'b0;
            test_pair_o <= 1'b0;
        end else if (ce_i) begin
            stat_q <= stat_d;
            stat_valid_q <= stat_valid_d;
            state_q <= state_d;
            cnt_q <= cnt_d;
            fail_q <= fail_d;
            bridge_tristate_o <= tri_d;
            test_gnd_o <= tgnd_d;
            test_vcc_o <= tvcc_d;
            test_pair_o <= tpair_d;
        end
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_q <= 3'h0;
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_q <= irq_next;
            irq_o <= |(irq_next & mask_q);
        end
    end
endmodule
`default_nettype wire

/* testbench/bsc_sense_model.sv */
`timescale 1ns/1ns
`default_nettype none
module bsc_sense_model (
    input wire logic [2:0] fault_i,
    input wire logic test_gnd_i,
    input wire logic test_vcc_i,
    input wire logic test_pair_i,
    output logic gnd_short_o,
    output logic vcc_short_o,
    output logic pair_short_o
);
    // Sensing only shows a short while its own test drives the pins
    assign gnd_short_o = test_gnd_i & fault_i[2];
    assign vcc_short_o = test_vcc_i & fault_i[1];
    assign pair_short_o = test_pair_i & fault_i[0];
endmodule
`default_nettype wire

/* testbench/bsc_check_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module bsc_chk #(parameter [15:0] TEST_CYC = 16'h0008) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic bridge_tristate_o,
    input wire logic test_gnd_o,
    input wire logic test_vcc_o,
    input wire logic test_pair_o
);
    default clocking @(posedge clock_i); endclocking
    // A frozen clock enable stretches every phase, so checks pause with it
    default disable iff (!rst_n_i || !ce_i);
    a_gnd_then_vcc: assert property ($fell(test_gnd_o) |-> test_vcc_o)
        else $error("vcc test missing");
    a_vcc_then_pair: assert property ($fell(test_vcc_o) |-> test_pair_o)
        else $error("pair test missing");
    a_vcc_after_gnd: assert property ($rose(test_vcc_o) |-> $past(test_gnd_o))
        else $error("vcc test out of order");
    a_tri_in_test: assert property ((test_gnd_o || test_vcc_o || test_pair_o) |-> bridge_tristate_o)
        else $error("bridge released in test");
    // Length fixed at the bench value of TEST_CYC
    a_gnd_length: assert property ($rose(test_gnd_o) |-> test_gnd_o [*8] ##1 !test_gnd_o)
        else $error("ground test length");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready too long");
    a_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_ready_cause: assert property (pready_o |-> $past(psel_i && penable_i))
        else $error("ready without access");
endmodule
bind bsc_check bsc_chk #(.TEST_CYC(TEST_CYC)) bsc_chk_i (.clock_i, .rst_n_i, .ce_i, .psel_i, .penable_i,
    .pready_o, .pslverr_o, .bridge_tristate_o, .test_gnd_o, .test_vcc_o, .test_pair_o);
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clock_i = 0, rst_n_i = 0, ce_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, se;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic pready_o, pslverr_o, gnd_short_i, vcc_short_i, pair_short_i, bridge_tristate_o;
    logic test_gnd_o, test_vcc_o, test_pair_o, irq_o;
    logic [2:0] fault = 3'h0, prev = 3'h7;
    // Row: fault, expected status, expected tristate
    logic [6:0] rows [5] = '{7'h47, 7'h2B, 7'h1D, 7'h71, 7'h0E};
    int err_count = 0, check_count = 0, n;
    always #10 clock_i = ~clock_i;
    bsc_check #(.TEST_CYC(16'h0008)) bsc_check_i (.clock_i, .rst_n_i, .ce_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .gnd_short_i, .vcc_short_i,
        .pair_short_i, .bridge_tristate_o, .test_gnd_o, .test_vcc_o, .test_pair_o, .irq_o);
    bsc_sense_model bsc_sense_model_i (.fault_i(fault), .test_gnd_i(test_gnd_o), .test_vcc_i(test_vcc_o),
        .test_pair_i(test_pair_o), .gnd_short_o(gnd_short_i), .vcc_short_o(vcc_short_i),
        .pair_short_o(pair_short_i));
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        int k;
        @(posedge clock_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= ad;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        k = 0;
        do @(posedge clock_i); while (pready_o !== 1'b1 && ++k < 50);
        if (pready_o !== 1'b1) begin
            err_count++;
            $display("unexpected pready expected 1 seen %b", pready_o);
        end
        rd = prdata_o;
        se = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clock_i);
        err_count++;
        close_out;
    end
    initial begin
        repeat (8) @(posedge clock_i);
        rst_n_i <= 1'b1;
        apb(0, 12'h160, 0);
        chk("status reset", 32'h7, rd);
        apb(0, 12'hF00, 0);
        chk("unmapped", 1, se);
        apb(1, 12'h140, 32'h1);
        foreach (rows[i]) begin
            fault <= rows[i][6:4];
            apb(1, 12'h014, 0);
            apb(1, 12'h014, 32'h80);
            for (n = 0; n < 99 && test_vcc_o !== 1'b1; n++) @(posedge clock_i);
            apb(0, 12'h160, 0);
            chk("status mid", {29'h0, rows[i][3], prev[1:0]}, {29'h0, rd[2:0]});
            for (n = 0; n < 99 && test_pair_o !== 1'b1; n++) @(posedge clock_i);
            for (n = 0; n < 99 && test_pair_o !== 1'b0; n++) @(posedge clock_i);
            apb(0, 12'h160, 0);
            chk("status", {23'h0, 1'b1, 5'h0, rows[i][3:1]}, rd);
            chk("tristate", rows[i][0], bridge_tristate_o);
            chk("retest", 0, test_gnd_o);
            prev = rows[i][3:1];
        end
        apb(1, 12'h160, 0);
        apb(0, 12'h160, 0);
        chk("status write", 32'h107, rd);
        apb(1, 12'h190, 32'h7);
        @(posedge clock_i);
        chk("irq on", 1, irq_o);
        apb(1, 12'h190, 0);
        @(posedge clock_i);
        chk("mask off", 0, irq_o);
        apb(1, 12'h190, 32'h7);
        @(posedge clock_i);
        chk("mask on", 1, irq_o);
        apb(0, 12'h180, 0);
        chk("irq status", 32'h7, rd);
        @(posedge clock_i);
        chk("irq clear", 0, irq_o);
        apb(1, 12'h014, 0);
        apb(1, 12'h014, 32'h80);
        repeat (4) @(posedge clock_i);
        chk("mid test", 1, test_gnd_o);
        ce_i <= 1'b0;
        repeat (20) @(posedge clock_i);
        chk("frozen", 1, test_gnd_o);
        ce_i <= 1'b1;
        rst_n_i <= 1'b0;
        @(posedge clock_i);
        chk("reset tri", 1, bridge_tristate_o);
        chk("reset test", 0, test_gnd_o);
        repeat (8) @(posedge clock_i);
        rst_n_i <= 1'b1;
        apb(0, 12'h160, 0);
        chk("status after reset", 32'h7, rd);
        apb(1, 12'h140, 0);
        fault <= 3'h7;
        apb(1, 12'h014, 0);
        apb(1, 12'h014, 32'h80);
        repeat (3) @(posedge clock_i);
        chk("no check tri", 0, bridge_tristate_o);
        chk("no check test", 0, test_gnd_o);
        close_out;
    end
endmodule
`default_nettype wire
